/* File: memory_parity_csr_bench.sv */
/*
 * Self-checking bench for the parity register block.
 * Assumes the array model answers every request; bus pins move 5 ns after edges.
 */
module memory_parity_csr_bench;
	timeunit 1ns;
	timeprecision 1ns;
	import mpcsr_pkg::*;
	logic clk_i = 0, nrst_i = 0, bus_init_i = 0, bus_sync_i = 0, bus_din_i = 0, bus_dout_i = 0;
	logic bus_wtbt_i = 0, bus_bs7_i = 0, refresh_i = 0, slow = 0, mem_done_i;
	logic [ADDR_W-1:0] bus_addr_i = '0, mem_addr_o, a1, a2;
	logic [DATA_W-1:0] bus_wdata_i = '0, mem_rdata_i, bus_rdata_o, mem_wdata_o, got, d;
	logic [JMP_W-1:0] jumper_i = '0;
	logic [1:0] mem_rpar_i, mem_be_o, mem_wpar_o;
	logic bus_drive_o, bus_reply_o, parity_flag_line_low_o, parity_flag_line_high_o, flag;
	logic mem_req_o, mem_we_o, strobe_inhibit_o, error_led_o;
	int fail_count = 0, samples_checked = 0;
	mpcsr_top mpcsr_top_i (.*);
	mpcsr_mem_model mpcsr_mem_model_i (.clk_i(clk_i), .slow_i(slow), .req_i(mem_req_o),
		.we_i(mem_we_o), .addr_i(mem_addr_o), .wdata_i(mem_wdata_o), .wpar_i(mem_wpar_o),
		.rdata_o(mem_rdata_i), .rpar_o(mem_rpar_i), .done_o(mem_done_i));
	always #25 clk_i = ~clk_i;
	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	task give_verdict;
		$display("checks %0d mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	task check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			fail_count++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// One whole bus transfer; bounded waits on the reply
	task xfer(input logic rd, input logic io, input logic [21:0] a, input logic [15:0] wd);
		int n;
		@(posedge clk_i) #5;
		bus_addr_i = a;
		bus_bs7_i = io;
		bus_sync_i = 1;
		repeat (4) @(posedge clk_i);
		#5 bus_wdata_i = wd;
		if (rd) bus_din_i = 1;
		else bus_dout_i = 1;
		n = 0;
		do begin @(posedge clk_i) #1 n++; end while (bus_reply_o !== 1'b1 && n < 40);
		if (n >= 40) fail_count++;
		got = bus_rdata_o;
		flag = parity_flag_line_low_o;
		#4 bus_din_i = 0;
		bus_dout_i = 0;
		n = 0;
		do begin @(posedge clk_i) #1 n++; end while (bus_reply_o !== 1'b0 && n < 40);
		if (n >= 40) fail_count++;
		#4 bus_sync_i = 0;
		repeat (6) @(posedge clk_i);
		// Leave the caller off the edge, so its next pin change is not a race
		#5;
	endtask
	task csr_wr(input logic [15:0] v); xfer(0, 1, {17'h0, jumper_i, 1'b0}, v); endtask
	task csr_rd; xfer(1, 1, {17'h0, jumper_i, 1'b0}, 16'h0000); endtask
	// Expected view of the register with the low failed-address field shown
	function automatic logic [15:0] seg_view(input logic [21:0] a, input logic en);
		return {4'h8, a[17:11], 4'h0, en};
	endfunction
	initial begin #200000; fail_count++; give_verdict(); end
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	initial begin
		void'($urandom(37243));
		jumper_i = $urandom;
		repeat (5) @(posedge clk_i);
		#5 nrst_i = 1;
		csr_rd();
		check("reset bits", got & 16'hC005, 16'h0000);
		csr_wr(16'hFFFF);
		csr_rd();
		check("writable bits", got & 16'hF01F, 16'hC005);
		check("led on", error_led_o, 1'b1);
		csr_wr(16'h0000);
		check("led off", error_led_o, 1'b0);
		// Low-lane byte write must leave the high-lane bits alone
		bus_wtbt_i = 1;
		csr_wr(16'hFF01);
		bus_wtbt_i = 0;
		csr_rd();
		check("low byte write", got & 16'hC005, 16'h0001);
		// Clean random traffic with both array speeds
		for (int i = 0; i < 6; i++) begin
			a1 = $urandom & 22'h3FFFFE;
			d = $urandom;
			slow = i[0];
			xfer(0, 0, a1, d);
			xfer(1, 0, a1, 16'h0000);
			check("array data", got, d);
			check("clean flag", flag, 1'b0);
		end
		// Plant wrong parity at two segments, extended view selected
		a1 = $urandom & 22'h3FFFFE;
		a2 = a1 ^ 22'h3FF800;
		csr_wr(16'h4005);
		xfer(0, 0, a1, 16'h1234);
		xfer(0, 0, a2, 16'hA5C3);
		// Low field in view first, then bit 14 set by read-modify-write
		csr_wr(16'h0001);
		xfer(1, 0, a1, 16'h0000);
		check("error flag", flag, 1'b1);
		check("error data", got, 16'h1234);
		csr_rd();
		check("first read", got, seg_view(a1, 1'b1));
		csr_wr(got | 16'h4000);
		csr_rd();
		check("upper view", got & 16'hF1FF, {4'hC, 3'h0, a1[21:18], 5'h01});
		csr_wr(16'h0001);
		xfer(1, 0, a2, 16'h0000);
		csr_rd();
		check("newest address", got, seg_view(a2, 1'b1));
		// Refresh suppresses, disabled enable still records
		refresh_i = 1;
		xfer(1, 0, a1, 16'h0000);
		refresh_i = 0;
		check("refresh flag", flag, 1'b0);
		csr_wr(16'h0000);
		xfer(1, 0, a1, 16'h0000);
		check("disabled flag", flag, 1'b0);
		check("led set", error_led_o, 1'b1);
		@(posedge clk_i) #5 bus_init_i = 1;
		repeat (3) @(posedge clk_i);
		#5 bus_init_i = 0;
		repeat (6) @(posedge clk_i);
		csr_rd();
		check("after init", got, seg_view(a1, 1'b0) & 16'h7FFF);
		check("led after init", error_led_o, 1'b0);
		// A mid-run power-up reset must not disturb the captured address
		nrst_i = 0;
		repeat (2) @(posedge clk_i);
		#5 nrst_i = 1;
		csr_rd();
		check("after reset", got, seg_view(a1, 1'b0) & 16'h7FFF);
		give_verdict();
	end
endmodule

/* File: mpcsr_mem_model.sv */
/*
 * Behavioural memory array that answers the register block's array requests.
 * Assumes one clock and word writes; slow_i stretches the answer.
 */
module mpcsr_mem_model (
	// Clock and pacing
	input  wire logic        clk_i,
	input  wire logic        slow_i,
	// Requests from the block
	input  wire logic        req_i,
	input  wire logic        we_i,
	input  wire logic [21:0] addr_i,
	input  wire logic [15:0] wdata_i,
	input  wire logic [1:0]  wpar_i,
	// Answers
	output logic [15:0]      rdata_o,
	output logic [1:0]       rpar_o,
	output logic             done_o
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [15:0] data_store [logic [21:0]];
	logic [1:0]  par_store [logic [21:0]];
	logic [21:0] a;
	logic        w;
	initial begin
		done_o = 1'b0;
		rdata_o = 16'h0000;
		rpar_o = 2'h0;
	end
	// Store on request, answer later; data lines scramble when not valid
	always @(posedge clk_i) begin
		if (req_i === 1'b1) begin
			a = addr_i;
			w = we_i;
			if (w) begin
				data_store[a] = wdata_i;
				par_store[a] = wpar_i;
			end
			repeat (slow_i ? 4 : 1) @(posedge clk_i);
			done_o <= 1'b1;
			rdata_o <= data_store.exists(a) ? data_store[a] : 16'h0000;
			rpar_o <= par_store.exists(a) ? par_store[a] : 2'h2;
			@(posedge clk_i);
			done_o <= 1'b0;
			rdata_o <= ~rdata_o;
			rpar_o <= ~rpar_o;
		end
	end
endmodule

/* File: mpcsr_parity.sv */
/*
 * Shared definitions for the parity control/status register block, plus the
 * byte-parity generator/checker that the register block instantiates.
 * Assumes one clock domain; the checker is purely combinational and is fed
 * either the write data from the bus or the read data from the memory array.
 */

package mpcsr_pkg;

	// ---------------------------------------------------------------
	// Widths
	// ---------------------------------------------------------------
	localparam int ADDR_W = 22;
	localparam int DATA_W = 16;
	localparam int JMP_W  = 4;
	localparam int SEG_W  = 7;
	localparam int EXT_W  = 4;
	localparam int LANE_W = 8;

	// ---------------------------------------------------------------
	// Register field positions
	// ---------------------------------------------------------------
	localparam int CSR_ENABLE   = 0;
	localparam int CSR_WRONG    = 2;
	localparam int CSR_ADDR_LSB = 5;
	localparam int CSR_ADDR_MSB = 11;
	localparam int CSR_EXT      = 14;
	localparam int CSR_PERR     = 15;
	localparam int HI_LANE_LSB  = 8;

	// Failed-address bits kept: 1K segment and the extended upper bits
	localparam int SEG_LSB = 11;
	localparam int SEG_MSB = 17;
	localparam int EXT_LSB = 18;
	localparam int EXT_MSB = 21;

	// Bus address bits compared against the select jumpers
	localparam int SEL_LSB = 1;
	localparam int SEL_MSB = 4;

	// Expected total parity per byte lane: lane 0 even, lane 1 odd
	localparam logic [1:0] PAR_ODD_LANES = 2'h2;

	localparam logic [DATA_W-1:0] CSR_ZERO  = 16'h0000;
	localparam logic [1:0]        LANE_ALL  = 2'h3;
	localparam logic [1:0]        LANE_LOW  = 2'h1;
	localparam logic [1:0]        LANE_HIGH = 2'h2;

	// ---------------------------------------------------------------
	// Types
	// ---------------------------------------------------------------
	typedef enum logic [3:0] {
		ST_IDLE    = 4'h1,
		ST_ADDR    = 4'h2,
		ST_MEMWAIT = 4'h4,
		ST_REPLY   = 4'h8
	} mpcsr_state_type;

	// One sample of every bus pin the block looks at
	typedef struct packed {
		logic              init;
		logic              sync;
		logic              din;
		logic              dout;
		logic              wtbt;
		logic              bs7;
		logic [JMP_W-1:0]  jumper;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
	} mpcsr_bus_type;

endpackage

module mpcsr_parity (
	// Data word and its stored parity
	input  wire logic [mpcsr_pkg::DATA_W-1:0] data_i,
	input  wire logic [1:0]                   stored_par_i,
	// Diagnostic control
	input  wire logic                         force_wrong_i,
	// Results
	output logic [1:0]                        gen_par_o,
	output logic                              error_o
);
	import mpcsr_pkg::*;

	logic [1:0] lane_err;

	// ---------------------------------------------------------------
	// Per-lane generate and check
	// ---------------------------------------------------------------
	for (genvar b = 0; b < 2; b++) begin : g_lane
		logic ones;
		assign ones = ^data_i[b*LANE_W +: LANE_W];
		// Generated bit makes the lane's total match what the checker expects
		assign gen_par_o[b] = ones ^ PAR_ODD_LANES[b] ^ force_wrong_i; // [RULE5]
		assign lane_err[b]  = (ones ^ stored_par_i[b]) != PAR_ODD_LANES[b]; // [RULE15]
	end

	assign error_o = |lane_err; // [RULE15]

endmodule

/* File: mpcsr_top.sv */
/*
 * Parity control/status register of a parity-protected memory module,
 * together with the bus-cycle sequencing that reads it, writes it, and
 * forwards memory reads and writes to the array.
 * Assumes bus pins arrive asynchronous to clk_i; the memory array and the
 * refresh logic sit on clk_i and answer a request with mem_done_i.
 */
//
// Functional notes
// [RULE1] Register reachable by ordinary bus reads and writes
// [RULE2] Bits 1,3,4,12,13 read zero, ignore writes
// [RULE3] Enabled read error drives both parity flags
// [RULE4] Enable bit 0 read/write, cleared by reset/init
// [RULE5] Bit 2 makes memory writes store wrong parity
// [RULE6] Bit 2 read/write, cleared by reset/init
// [RULE7] Read error captures A11-A17 and A18-A21
// [RULE8] Bit 14 selects low or high captured field
// [RULE9] Software reads twice for 22-bit addresses
// [RULE10] Captured address read/write, survives reset/init
// [RULE11] Nothing below A11 is kept
// [RULE12] Newest error overwrites the captured address
// [RULE13] Bit 15 sets on error, lights LED
// [RULE14] Bit 15 read/write, cleared by init, sticky
// [RULE15] Low lane even, high lane odd parity
// [RULE16] No checking on register or refresh cycles
// [RULE17] Select by jumpers on address bits 1-4
// [RULE18] Bit 14 is plain storage, selects view
// [RULE19] Sixteen-bit register, listed bits writable

module mpcsr_top (
	// Clock and reset
	input  wire logic                         clk_i,
	input  wire logic                         nrst_i,
	// Bus pins
	input  wire logic                         bus_init_i,
	input  wire logic                         bus_sync_i,
	input  wire logic                         bus_din_i,
	input  wire logic                         bus_dout_i,
	input  wire logic                         bus_wtbt_i,
	input  wire logic                         bus_bs7_i,
	input  wire logic [mpcsr_pkg::ADDR_W-1:0] bus_addr_i,
	input  wire logic [mpcsr_pkg::DATA_W-1:0] bus_wdata_i,
	// Register select jumpers
	input  wire logic [mpcsr_pkg::JMP_W-1:0]  jumper_i,
	// Memory array and refresh side
	input  wire logic [mpcsr_pkg::DATA_W-1:0] mem_rdata_i,
	input  wire logic [1:0]                   mem_rpar_i,
	input  wire logic                         mem_done_i,
	input  wire logic                         refresh_i,
	// Bus answers
	output logic [mpcsr_pkg::DATA_W-1:0]      bus_rdata_o,
	output logic                              bus_drive_o,
	output logic                              bus_reply_o,
	output logic                              parity_flag_line_low_o,
	output logic                              parity_flag_line_high_o,
	// Memory array requests
	output logic                              mem_req_o,
	output logic                              mem_we_o,
	output logic [1:0]                        mem_be_o,
	output logic [mpcsr_pkg::ADDR_W-1:0]      mem_addr_o,
	output logic [mpcsr_pkg::DATA_W-1:0]      mem_wdata_o,
	output logic [1:0]                        mem_wpar_o,
	output logic                              strobe_inhibit_o,
	// Indicator
	output logic                              error_led_o
);
	import mpcsr_pkg::*;

	// ---------------------------------------------------------------
	// State
	// ---------------------------------------------------------------
	typedef struct packed {
		mpcsr_bus_type     meta;
		mpcsr_bus_type     sync2;
		logic              sync_prev;
		mpcsr_state_type   st;
		logic [ADDR_W-1:0] addr;
		logic              csr_sel;
		logic              enable;
		logic              wrong;
		logic              ext;
		logic              perr;
		logic [DATA_W-1:0] rdata;
		logic              drive;
		logic              reply;
		logic              flag;
		logic              mem_req;
		logic              mem_we;
		logic [1:0]        mem_be;
		logic [DATA_W-1:0] mem_wdata;
		logic [1:0]        mem_wpar;
		logic              inhibit;
	} mpcsr_state_bundle_type;

	mpcsr_state_bundle_type r;
	mpcsr_state_bundle_type next_r;

	// Captured failed address; deliberately outside the reset domain
	logic [SEG_W-1:0] seg;
	logic [EXT_W-1:0] ext_addr;
	logic [SEG_W-1:0] next_seg;
	logic [EXT_W-1:0] next_ext_addr;

	mpcsr_bus_type     b;
	mpcsr_bus_type     pin_sample;
	logic [DATA_W-1:0] par_data;
	logic [1:0]        gen_par;
	logic              par_err;
	logic [DATA_W-1:0] csr_view;

	// ---------------------------------------------------------------
	// Parity generator / checker
	// ---------------------------------------------------------------
	// One instance serves both directions: the array is only read while
	// waiting in ST_MEMWAIT, and write data is only sampled before that.
	assign par_data = (r.st == ST_MEMWAIT) ? mem_rdata_i : b.wdata;

	mpcsr_parity mpcsr_parity_i (
		.data_i        (par_data),
		.stored_par_i  (mem_rpar_i),
		.force_wrong_i (r.wrong),
		.gen_par_o     (gen_par),
		.error_o       (par_err)
	);

	// Pin bundle and its synchronised copy
	assign pin_sample = '{init: bus_init_i, sync: bus_sync_i, din: bus_din_i,
		dout: bus_dout_i, wtbt: bus_wtbt_i, bs7: bus_bs7_i, jumper: jumper_i,
		addr: bus_addr_i, wdata: bus_wdata_i};
	assign b = r.sync2;

	// ---------------------------------------------------------------
	// Read view of the register
	// ---------------------------------------------------------------
	// Unused positions keep only the zero default, so they read as zero
	always_comb begin
		csr_view             = CSR_ZERO; // [RULE2]
		csr_view[CSR_ENABLE] = r.enable; // [RULE4]
		csr_view[CSR_WRONG]  = r.wrong; // [RULE6]
		csr_view[CSR_EXT]    = r.ext; // [RULE18]
		csr_view[CSR_PERR]   = r.perr; // [RULE14]
		if (r.ext) begin
			csr_view[CSR_ADDR_LSB +: EXT_W] = ext_addr; // [RULE8]
		end else begin
			csr_view[CSR_ADDR_MSB:CSR_ADDR_LSB] = seg; // [RULE8]
		end
	end

	// ---------------------------------------------------------------
	// Next-state logic
	// ---------------------------------------------------------------
	always_comb begin
		logic lo_wr;
		logic hi_wr;
		int   pos;
		lo_wr         = 1'b0;
		hi_wr         = 1'b0;
		pos           = 0;
		next_r        = r;
		next_seg      = seg;
		next_ext_addr = ext_addr;
		next_r.meta   = pin_sample;
		next_r.sync2  = r.meta;
		next_r.sync_prev = b.sync;
		next_r.mem_req   = 1'b0;

		unique case (r.st)
			ST_IDLE: begin
				// Address phase: decode the register select on the leading edge
				if (b.sync && !r.sync_prev) begin
					next_r.addr    = b.addr;
					next_r.csr_sel = b.bs7 && (b.addr[SEL_MSB:SEL_LSB] == b.jumper); // [RULE17]
					next_r.inhibit = next_r.csr_sel; // [RULE17]
					next_r.st      = ST_ADDR;
				end
			end
			ST_ADDR: begin
				if (!b.sync) begin
					next_r.inhibit = 1'b0;
					next_r.st      = ST_IDLE;
				end else if (b.din) begin
					if (r.csr_sel) begin
						// Register read answers at once, no array access
						next_r.rdata = csr_view; // [RULE1]
						next_r.drive = 1'b1;
						next_r.reply = 1'b1;
						next_r.st    = ST_REPLY;
					end else begin
						next_r.mem_req = 1'b1;
						next_r.mem_we  = 1'b0;
						next_r.mem_be  = LANE_ALL;
						next_r.st      = ST_MEMWAIT;
					end
				end else if (b.dout) begin
					lo_wr = !b.wtbt || !r.addr[0];
					hi_wr = !b.wtbt || r.addr[0];
					if (r.csr_sel) begin
						// Only listed bits are stored; the rest are dropped
						if (lo_wr) begin
							next_r.enable = b.wdata[CSR_ENABLE]; // [RULE4] [RULE19]
							next_r.wrong  = b.wdata[CSR_WRONG]; // [RULE6] [RULE19]
						end
						if (hi_wr) begin
							next_r.ext  = b.wdata[CSR_EXT]; // [RULE18]
							next_r.perr = b.wdata[CSR_PERR]; // [RULE14]
						end
						// Address field writes land in whichever half is in view
						for (int i = 0; i < SEG_W; i++) begin
							pos = CSR_ADDR_LSB + i;
							if ((pos >= HI_LANE_LSB) ? hi_wr : lo_wr) begin
								if (!r.ext) begin
									next_seg[i] = b.wdata[pos]; // [RULE10]
								end else if (i < EXT_W) begin
									next_ext_addr[i] = b.wdata[pos]; // [RULE10]
								end
							end
						end
						next_r.reply = 1'b1; // [RULE1]
						next_r.st    = ST_REPLY;
					end else begin
						next_r.mem_req   = 1'b1;
						next_r.mem_we    = 1'b1;
						next_r.mem_be    = b.wtbt ? (r.addr[0] ? LANE_HIGH : LANE_LOW)
							: LANE_ALL;
						next_r.mem_wdata = b.wdata;
						next_r.mem_wpar  = gen_par; // [RULE5]
						next_r.st        = ST_MEMWAIT;
					end
				end
			end
			ST_MEMWAIT: begin
				if (mem_done_i) begin
					if (!r.mem_we) begin
						next_r.rdata = mem_rdata_i;
						next_r.drive = 1'b1;
						// Register cycles never reach here; refresh is masked
						if (par_err && !refresh_i) begin // [RULE16]
							next_r.flag   = r.enable; // [RULE3]
							next_r.perr   = 1'b1; // [RULE13]
							next_seg      = r.addr[SEG_MSB:SEG_LSB]; // [RULE7] [RULE11] [RULE12]
							next_ext_addr = r.addr[EXT_MSB:EXT_LSB]; // [RULE7] [RULE12]
						end
					end
					next_r.reply = 1'b1;
					next_r.st    = ST_REPLY;
				end
			end
			ST_REPLY: begin
				// Hold the answer until the master drops its strobe; a
				// read-modify-write then continues with its write phase
				if (!b.din && !b.dout) begin
					next_r.reply  = 1'b0;
					next_r.drive  = 1'b0;
					next_r.flag   = 1'b0;
					next_r.mem_we = 1'b0;
					next_r.st     = ST_ADDR;
				end
			end
		endcase

		// Bus initialise clears control bits only; captured address survives
		if (b.init) begin
			next_r.enable = 1'b0; // [RULE4]
			next_r.wrong  = 1'b0; // [RULE6]
			next_r.ext    = 1'b0;
			next_r.perr   = 1'b0; // [RULE14]
		end
	end

	// ---------------------------------------------------------------
	// Registers
	// ---------------------------------------------------------------
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			r    <= '0;
			r.st <= ST_IDLE;
		end else begin
			r <= next_r;
		end
	end

	// No reset here: a failed address must survive power-up and init
	always_ff @(posedge clk_i) begin
		seg      <= next_seg; // [RULE10]
		ext_addr <= next_ext_addr; // [RULE10]
	end

	// ---------------------------------------------------------------
	// Outputs
	// ---------------------------------------------------------------
	assign bus_rdata_o             = r.rdata;
	assign bus_drive_o             = r.drive;
	assign bus_reply_o             = r.reply;
	assign parity_flag_line_low_o  = r.flag; // [RULE3]
	assign parity_flag_line_high_o = r.flag; // [RULE3]
	assign mem_req_o               = r.mem_req;
	assign mem_we_o                = r.mem_we;
	assign mem_be_o                = r.mem_be;
	assign mem_addr_o              = r.addr;
	assign mem_wdata_o             = r.mem_wdata;
	assign mem_wpar_o              = r.mem_wpar;
	assign strobe_inhibit_o        = r.inhibit;
	assign error_led_o             = r.perr; // [RULE13]

endmodule

/* File: mpcsr_top_sva.sv */
/*
 * Port-level checker for the parity register block.
 * Assumes a single clock domain; widths and lane masks are written out, not taken from the package.
 */
module mpcsr_top_sva (
	// Clock and reset
	input  wire logic        clk_i,
	input  wire logic        nrst_i,
	// Watched pins
	input  wire logic        bus_init_i,
	input  wire logic        mem_done_i,
	input  wire logic        bus_drive_o,
	input  wire logic        bus_reply_o,
	input  wire logic        parity_flag_line_low_o,
	input  wire logic        parity_flag_line_high_o,
	input  wire logic        mem_req_o,
	input  wire logic        mem_we_o,
	input  wire logic [1:0]  mem_be_o,
	input  wire logic [15:0] mem_wdata_o,
	input  wire logic [1:0]  mem_wpar_o,
	input  wire logic        strobe_inhibit_o,
	input  wire logic        error_led_o
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!nrst_i);

	// ----------------------------------------
	// Properties
	// ----------------------------------------
	a_flags_paired: assert property (parity_flag_line_low_o == parity_flag_line_high_o)
		else $error("parity flag lines differ");
	a_flag_with_data: assert property (parity_flag_line_low_o
		|-> bus_drive_o && bus_reply_o)
		else $error("parity flag without read data");
	a_flag_from_array: assert property ($rose(parity_flag_line_low_o)
		|-> $past(mem_done_i) && error_led_o)
		else $error("parity flag not tied to array read");
	// Init is synchronised, so its clearing effect lags by a few edges
	a_led_sticky: assert property ($fell(error_led_o) |-> strobe_inhibit_o
		|| $past(bus_init_i, 2) || $past(bus_init_i, 3) || $past(bus_init_i, 4)
		|| $past(bus_init_i, 5))
		else $error("error indicator dropped by itself");
	a_no_array_csr: assert property (strobe_inhibit_o |-> !mem_req_o)
		else $error("array request during register access");
	a_req_single: assert property (mem_req_o |=> !mem_req_o)
		else $error("array request longer than one cycle");
	a_reply_follows: assert property (mem_done_i && !strobe_inhibit_o |=> bus_reply_o)
		else $error("no reply after array answer");
	a_lane_parity: assert property (mem_req_o && mem_we_o && mem_be_o == 2'h3
		|-> (^{mem_wdata_o[7:0], mem_wpar_o[0]}) != (^{mem_wdata_o[15:8], mem_wpar_o[1]}))
		else $error("lane parity senses not opposite");
	a_drive_reply: assert property (bus_drive_o |-> bus_reply_o)
		else $error("data driven without reply");
endmodule

bind mpcsr_top mpcsr_top_sva mpcsr_top_sva_i (.clk_i, .nrst_i, .bus_init_i, .mem_done_i,
	.bus_drive_o, .bus_reply_o, .parity_flag_line_low_o, .parity_flag_line_high_o, .mem_req_o,
	.mem_we_o, .mem_be_o, .mem_wdata_o, .mem_wpar_o, .strobe_inhibit_o, .error_led_o);
